/* File: ipls_top.sv */
/*
  Interrupt priority level select: two 8-bit priority registers on an
  AHB-Lite slave, and a two-level fixed-order selector of pending requests.
  Assumes src_req comes from logic on hclk, and hw_standby comes from a pin
  so it is synchronised here. The single slave on the bus: hready is the
  looped-back hreadyout.
*/
// The register offsets and the AHB-Lite slave port were decided locally.
module ipls_top
  import ipls_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic hw_standby,
  input wire logic [NUM_SRC-1:0] src_req,
  output logic irq_valid,
  output logic [4:0] irq_src,
  output logic irq_level
);

  ipls_state_s s;
  ipls_state_s next_s;
  logic [NUM_SRC-1:0] src_lvl;
  logic [NUM_SRC-1:0] hi_req;
  logic addr_phase;
  logic [11:0] addr_lo;

  // Level that a request line gets from the two registers
  function automatic logic level_of(input logic [4:0] idx,
                                    input logic [7:0] pa,
                                    input logic [7:0] pb);
    logic lv;
    lv = 1'b0;
    unique case (idx)
      SRC_EXT0: lv = pa[BIT_EXT0];
      SRC_EXT1: lv = pa[BIT_EXT1];
      SRC_EXT2, SRC_EXT3: lv = pa[BIT_EXT2_3];
      SRC_EXT4, SRC_EXT5: lv = pa[BIT_EXT4_5];
      SRC_WDT_REF: lv = pa[BIT_WDT_REF];
      SRC_TIMER0: lv = pa[BIT_TIMER0];
      SRC_TIMER1: lv = pa[BIT_TIMER1];
      SRC_TIMER2: lv = pa[BIT_TIMER2];
      SRC_TIMER3: lv = pb[BIT_TIMER3];
      SRC_TIMER4: lv = pb[BIT_TIMER4];
      SRC_DMA0, SRC_DMA1: lv = pb[BIT_DMA];
      SRC_SERIAL0: lv = pb[BIT_SERIAL0];
      SRC_SERIAL1: lv = pb[BIT_SERIAL1];
      SRC_ADC: lv = pb[BIT_ADC];
      default: lv = 1'b0;
    endcase
    return lv;
  endfunction : level_of

  // Per-line level; the spare bits of B are never looked at
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_lvl
      assign src_lvl[gi] = level_of(5'(gi), s.prio_a, s.prio_b);
      assign hi_req[gi] = src_req[gi] & src_lvl[gi];
    end
  endgenerate

  // Address phase decode
  assign addr_phase = hsel & (htrans == HTRANS_NONSEQ) & hready;
  assign addr_lo = haddr[11:0];

  // Next state: bus slave, standby clear, selector
  always_comb
  begin
    logic [31:0] rd;
    logic found;
    next_s = s;
    rd = UNMAPPED_READ;
    found = 1'b0;
    next_s.ready = 1'b1;
    // Data phase of a write lands here; unmapped writes are dropped
    if (s.dp_valid && s.dp_write)
    begin
      if (s.dp_sel_a)
        next_s.prio_a = hwdata[7:0];
      if (s.dp_sel_b)
        next_s.prio_b = hwdata[7:0];
    end
    // Standby wins over a write in flight
    if (s.stby_sync)
    begin
      next_s.prio_a = PRIO_A_RESET;
      next_s.prio_b = PRIO_B_RESET;
    end
    // Read data is fetched at the address phase so it stands in the data
    // phase with no wait state; forwarding covers write-then-read
    if (addr_phase && !hwrite)
    begin
      if (addr_lo == (OFS_PRIO_A & OFS_MASK))
        rd = {24'h00_0000, next_s.prio_a};
      else if (addr_lo == (OFS_PRIO_B & OFS_MASK))
        rd = {24'h00_0000, next_s.prio_b};
    end
    next_s.rdata = rd;
    next_s.dp_valid = addr_phase;
    next_s.dp_write = addr_phase & hwrite;
    next_s.dp_sel_a = addr_phase & (addr_lo == OFS_PRIO_A);
    next_s.dp_sel_b = addr_phase & (addr_lo == OFS_PRIO_B);
    // Pin synchroniser: second stage alone is read
    next_s.stby_meta = hw_standby;
    next_s.stby_sync = s.stby_meta;
    // Selector: level 1 first, then level 0, lowest line number wins
    next_s.grant = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (!found && hi_req[i])
      begin
        found = 1'b1;
        next_s.grant.valid = 1'b1;
        next_s.grant.src = 5'(i);
        next_s.grant.level = 1'b1;
      end
    end
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (!found && src_req[i])
      begin
        found = 1'b1;
        next_s.grant.valid = 1'b1;
        next_s.grant.src = 5'(i);
        next_s.grant.level = 1'b0;
      end
    end
    // Nothing is offered while the chip sits in hardware standby
    if (s.stby_sync)
      next_s.grant = '0;
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.ready <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Outputs straight from flops
  assign hreadyout = s.ready;
  assign hresp = 1'b0 & s.ready;
  assign hrdata = s.rdata;
  assign irq_valid = s.grant.valid;
  assign irq_src = s.grant.src;
  assign irq_level = s.grant.level;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_ext0_map: assert property (irq_valid && irq_src == SRC_EXT0
    |-> irq_level == $past(s.prio_a[BIT_EXT0]))
    else $error("ext0 level does not follow register A bit 7");

  a_ext1_map: assert property (irq_valid && irq_src == SRC_EXT1
    |-> irq_level == $past(s.prio_a[BIT_EXT1]))
    else $error("ext1 level does not follow register A bit 6");

  a_ext23_map: assert property (irq_valid &&
    (irq_src == SRC_EXT2 || irq_src == SRC_EXT3)
    |-> irq_level == $past(s.prio_a[BIT_EXT2_3]))
    else $error("ext2/3 level does not follow register A bit 5");

  a_ext45_map: assert property (irq_valid &&
    (irq_src == SRC_EXT4 || irq_src == SRC_EXT5)
    |-> irq_level == $past(s.prio_a[BIT_EXT4_5]))
    else $error("ext4/5 level does not follow register A bit 4");

  a_wdt_map: assert property (irq_valid && irq_src == SRC_WDT_REF
    |-> irq_level == $past(s.prio_a[BIT_WDT_REF]))
    else $error("watchdog level does not follow register A bit 3");

  a_timer0_map: assert property (irq_valid && irq_src == SRC_TIMER0
    |-> irq_level == $past(s.prio_a[BIT_TIMER0]))
    else $error("timer0 level does not follow register A bit 2");

  a_timer12_map: assert property (irq_valid &&
    (irq_src == SRC_TIMER1 || irq_src == SRC_TIMER2)
    |-> irq_level == (irq_src == SRC_TIMER1 ?
        $past(s.prio_a[BIT_TIMER1]) : $past(s.prio_a[BIT_TIMER2])))
    else $error("timer1/2 level does not follow register A");

  a_timer34_map: assert property (irq_valid &&
    (irq_src == SRC_TIMER3 || irq_src == SRC_TIMER4)
    |-> irq_level == (irq_src == SRC_TIMER3 ?
        $past(s.prio_b[BIT_TIMER3]) : $past(s.prio_b[BIT_TIMER4])))
    else $error("timer3/4 level does not follow register B");

  a_dma_map: assert property (irq_valid &&
    (irq_src == SRC_DMA0 || irq_src == SRC_DMA1)
    |-> irq_level == $past(s.prio_b[BIT_DMA]))
    else $error("DMA level does not follow register B bit 5");

  a_serial_map: assert property (irq_valid &&
    (irq_src == SRC_SERIAL0 || irq_src == SRC_SERIAL1)
    |-> irq_level == (irq_src == SRC_SERIAL0 ?
        $past(s.prio_b[BIT_SERIAL0]) : $past(s.prio_b[BIT_SERIAL1])))
    else $error("serial level does not follow register B");

  a_adc_map: assert property (irq_valid && irq_src == SRC_ADC
    |-> irq_level == $past(s.prio_b[BIT_ADC]))
    else $error("A/D level does not follow register B bit 1");

  a_spare_inert: assert property ($stable(s.prio_a) &&
    ((s.prio_b ^ $past(s.prio_b)) & ~SPARE_MASK_B) == 8'h00
    |-> src_lvl == $past(src_lvl))
    else $error("spare bit of register B changed a level");

  a_stby_clear: assert property (s.stby_sync
    |=> s.prio_a == PRIO_A_RESET && s.prio_b == PRIO_B_RESET && !irq_valid)
    else $error("standby did not clear the priority registers");

  a_write_b: assert property (s.dp_valid && s.dp_write && s.dp_sel_b &&
    !s.stby_sync |=> s.prio_b == $past(hwdata[7:0]))
    else $error("write to register B was not stored");

  a_high_first: assert property (irq_valid && !irq_level
    |-> $past(hi_req) == '0 &&
        (($past(src_req) >> irq_src) & 17'h0_0001) != '0)
    else $error("level 0 granted while level 1 was pending");

  a_tie_order: assert property (irq_valid
    |-> ((irq_level ? $past(hi_req) : $past(src_req)) &
         ((17'h0_0001 << irq_src) - 17'h0_0001)) == '0)
    else $error("lower numbered request of equal level was skipped");

  a_req_served: assert property (!s.stby_sync && |src_req
    |=> irq_valid)
    else $error("pending request not presented next cycle");

  // Bus side: the slave never stalls and never signals an error
  a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("slave stalled or answered with an error");

  a_write_a: assert property (s.dp_valid && s.dp_write &&
    s.dp_sel_a && !s.stby_sync |=> s.prio_a == $past(hwdata[7:0]))
    else $error("write to register A was not stored");

  // Read data stands in the data phase, forwarded from a write just before
  a_read_a: assert property (addr_phase && !hwrite &&
    addr_lo == OFS_PRIO_A |=> hrdata == {24'h00_0000, s.prio_a})
    else $error("read of register A returned a stale value");

  a_read_b: assert property (addr_phase && !hwrite &&
    addr_lo == OFS_PRIO_B |=> hrdata == {24'h00_0000, s.prio_b})
    else $error("read of register B returned a stale value");

  a_unmapped_rd: assert property (addr_phase && !hwrite &&
    addr_lo != OFS_PRIO_A && addr_lo != OFS_PRIO_B
    |=> hrdata == UNMAPPED_READ)
    else $error("unmapped read did not return zero");

  // Zero outside read data phases keeps stale values off the bus
  a_rdata_idle: assert property (!(addr_phase && !hwrite)
    |=> hrdata == UNMAPPED_READ)
    else $error("read data left standing outside a data phase");

  a_regs_hold: assert property (!(s.dp_valid && s.dp_write) &&
    !s.stby_sync |=> $stable(s.prio_a) && $stable(s.prio_b))
    else $error("priority register changed with no write");

  a_unmapped_wr: assert property (s.dp_valid && s.dp_write &&
    !s.dp_sel_a && !s.dp_sel_b && !s.stby_sync
    |=> $stable(s.prio_a) && $stable(s.prio_b))
    else $error("unmapped write changed a priority register");

  // Standby is seen only through the second flop of the synchroniser
  a_stby_sync: assert property (s.stby_sync == $past(s.stby_meta))
    else $error("standby bypassed the synchroniser");

  // Grouped sources share one bit, so their levels never differ
  a_pair_ext23: assert property (
    src_lvl[SRC_EXT2] == s.prio_a[BIT_EXT2_3] &&
    src_lvl[SRC_EXT3] == s.prio_a[BIT_EXT2_3])
    else $error("external 2 and 3 levels do not share bit 5");

  a_pair_ext45: assert property (
    src_lvl[SRC_EXT4] == s.prio_a[BIT_EXT4_5] &&
    src_lvl[SRC_EXT5] == s.prio_a[BIT_EXT4_5])
    else $error("external 4 and 5 levels do not share bit 4");

  a_pair_dma: assert property (
    src_lvl[SRC_DMA0] == s.prio_b[BIT_DMA] &&
    src_lvl[SRC_DMA1] == s.prio_b[BIT_DMA])
    else $error("DMA channel levels do not share bit 5");

  // Selector sanity: a grant names a live line of the level it reports
  a_grant_live: assert property (irq_valid
    |-> (($past(src_req) >> irq_src) & 17'h0_0001) != '0)
    else $error("grant names a line that was not requesting");

  a_grant_level: assert property (irq_valid && irq_level
    |-> (($past(hi_req) >> irq_src) & 17'h0_0001) != '0)
    else $error("level 1 grant for a line not set to level 1");

  a_low_level: assert property (irq_valid && !irq_level
    |-> (($past(src_lvl) >> irq_src) & 17'h0_0001) == '0)
    else $error("level 0 grant for a line set to level 1");

  a_src_range: assert property (irq_valid |-> irq_src <= SRC_ADC)
    else $error("grant names a line beyond the last source");

  a_idle_none: assert property (src_req == '0 |=> !irq_valid)
    else $error("grant presented with no request pending");

  a_hi_served: assert property (!s.stby_sync && hi_req != '0
    |=> irq_valid && irq_level)
    else $error("pending level 1 request not presented at level 1");

endmodule : ipls_top

/* File: ipls_pkg.sv */
/*
  Constants and carrier types for the interrupt priority level select block.
  Assumes a 32-bit AHB-Lite fabric and seventeen request lines from the
  peripherals, already enabled and held until the CPU takes them.
*/
package ipls_pkg;

  // Register word offsets (low 12 address bits)
  localparam logic [11:0] OFS_PRIO_A = 12'h000;
  localparam logic [11:0] OFS_PRIO_B = 12'h004;
  localparam logic [11:0] OFS_MASK = 12'hFFC;
  localparam logic [7:0] PRIO_A_RESET = 8'h00;
  localparam logic [7:0] PRIO_B_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Field positions in priority_select_a
  localparam int BIT_EXT0 = 7;
  localparam int BIT_EXT1 = 6;
  localparam int BIT_EXT2_3 = 5;
  localparam int BIT_EXT4_5 = 4;
  localparam int BIT_WDT_REF = 3;
  localparam int BIT_TIMER0 = 2;
  localparam int BIT_TIMER1 = 1;
  localparam int BIT_TIMER2 = 0;
  // Field positions in priority_select_b
  localparam int BIT_TIMER3 = 7;
  localparam int BIT_TIMER4 = 6;
  localparam int BIT_DMA = 5;
  localparam int BIT_SPARE_HI = 4;
  localparam int BIT_SERIAL0 = 3;
  localparam int BIT_SERIAL1 = 2;
  localparam int BIT_ADC = 1;
  localparam int BIT_SPARE_LO = 0;
  localparam logic [7:0] SPARE_MASK_B = 8'h11;

  // Request line numbers; lower number wins among equal levels
  localparam int NUM_SRC = 17;
  localparam logic [4:0] SRC_EXT0 = 5'h00;
  localparam logic [4:0] SRC_EXT1 = 5'h01;
  localparam logic [4:0] SRC_EXT2 = 5'h02;
  localparam logic [4:0] SRC_EXT3 = 5'h03;
  localparam logic [4:0] SRC_EXT4 = 5'h04;
  localparam logic [4:0] SRC_EXT5 = 5'h05;
  localparam logic [4:0] SRC_WDT_REF = 5'h06;
  localparam logic [4:0] SRC_TIMER0 = 5'h07;
  localparam logic [4:0] SRC_TIMER1 = 5'h08;
  localparam logic [4:0] SRC_TIMER2 = 5'h09;
  localparam logic [4:0] SRC_TIMER3 = 5'h0A;
  localparam logic [4:0] SRC_TIMER4 = 5'h0B;
  localparam logic [4:0] SRC_DMA0 = 5'h0C;
  localparam logic [4:0] SRC_DMA1 = 5'h0D;
  localparam logic [4:0] SRC_SERIAL0 = 5'h0E;
  localparam logic [4:0] SRC_SERIAL1 = 5'h0F;
  localparam logic [4:0] SRC_ADC = 5'h10;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Selected request presented to the CPU acceptance logic
  typedef struct packed {
    logic valid;
    logic [4:0] src;
    logic level;
  } ipls_grant_s;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] prio_a;
    logic [7:0] prio_b;
    logic dp_valid;
    logic dp_write;
    logic dp_sel_a;
    logic dp_sel_b;
    logic [31:0] rdata;
    logic ready;
    logic stby_meta;
    logic stby_sync;
    ipls_grant_s grant;
  } ipls_state_s;

endpackage : ipls_pkg

/* File: ipls_far_model.sv */
/*
  Far-side model: peripheral request lines and the CPU that takes them.
  Assumes the bench posts or holds lines on hclk and the grant outputs of
  the priority block feed back into it.
*/
module ipls_far_model
  import ipls_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [NUM_SRC-1:0] held,
  input wire logic [NUM_SRC-1:0] post,
  input wire logic accept_en,
  input wire logic irq_valid,
  input wire logic [4:0] irq_src,
  output logic [NUM_SRC-1:0] src_req,
  output logic taken,
  output logic [4:0] taken_src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_SRC-1:0] pend;
  logic gap;

  // Posted lines stay up until taken; gap skips the stale grant cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend <= '0;
      gap <= 1'b0;
      taken <= 1'b0;
      taken_src <= 5'h00;
    end
    else if (!gap && accept_en && irq_valid)
    begin
      pend <= (pend | post) & ~({{(NUM_SRC-1){1'b0}}, 1'b1} << irq_src);
      gap <= 1'b1;
      taken <= 1'b1;
      taken_src <= irq_src;
    end
    else
    begin
      pend <= pend | post;
      gap <= 1'b0;
      taken <= 1'b0;
    end
  end

  // Held lines model level requesters that are never served here
  assign src_req = pend | held;
endmodule : ipls_far_model

/* File: ipls_top_tb.sv */
/*
  Self-checking bench for the priority level select block.
  Assumes the block is the only AHB-Lite slave, so hready is hreadyout.
*/
module ipls_top_tb
  import ipls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hw_standby = 1'b0;
  logic [NUM_SRC-1:0] held = '0;
  logic [NUM_SRC-1:0] post = '0;
  logic accept_en = 1'b0;
  logic hreadyout, hresp, irq_valid, irq_level, taken;
  logic [31:0] hrdata, rd;
  logic [4:0] irq_src, taken_src;
  logic [NUM_SRC-1:0] src_req;
  int fails = 0;
  int n_tests = 0;

  // 250 MHz clock
  initial
  begin
    forever #2 hclk = ~hclk;
  end

  ipls_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .hw_standby(hw_standby),
    .src_req(src_req), .irq_valid(irq_valid), .irq_src(irq_src),
    .irq_level(irq_level));

  ipls_far_model far (.hclk(hclk), .hresetn(hresetn), .held(held),
    .post(post), .accept_en(accept_en), .irq_valid(irq_valid),
    .irq_src(irq_src), .src_req(src_req), .taken(taken),
    .taken_src(taken_src));

  // One comparison; case equality so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Single word transfer; no latency assumed, each phase waits on hready
  task automatic ahb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    n = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 64);
    if (hreadyout !== 1'b1)
      chk("addr hready", 32'h0000_0001, {31'h00000000, hreadyout});
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0000_0000;
    n = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 64);
    if (hreadyout !== 1'b1)
      chk("data hready", 32'h0000_0001, {31'h00000000, hreadyout});
    chk("hresp", 32'h0000_0000, {31'h00000000, hresp});
    rd = hrdata;
  endtask : ahb

  task automatic rdchk(input string what, input logic [11:0] a,
                       input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rdchk

  // Grant is one edge behind the lines; three edges leave margin
  task automatic drive(input logic [NUM_SRC-1:0] lines);
    @(posedge hclk);
    held <= lines;
    repeat (3) @(posedge hclk);
    #1;
  endtask : drive

  // Only one field set, lines below s idle: s must win at level 1
  task automatic prio_case(input logic [4:0] s, input logic on_b,
                           input int b);
    logic [31:0] v;
    v = 32'h0000_0001 << b;
    ahb(1'b1, OFS_PRIO_A, on_b ? 32'h0000_0000 : v);
    ahb(1'b1, OFS_PRIO_B, on_b ? v : 32'h0000_0000);
    drive({NUM_SRC{1'b1}} << s);
    chk("grant source", {27'h0000000, s}, {27'h0000000, irq_src});
    chk("grant level", 32'h0000_0001, {31'h00000000, irq_level});
  endtask : prio_case

  task automatic take_chk(input logic [4:0] exp);
    int n;
    n = 0;
    do @(posedge hclk); while (taken !== 1'b1 && ++n < 32);
    chk("taken", 32'h0000_0001, {31'h00000000, taken});
    chk("taken source", {27'h0000000, exp}, {27'h0000000, taken_src});
  endtask : take_chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // Main sequence of tests
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("prio_a reset", OFS_PRIO_A, 32'h0000_0000);
    rdchk("prio_b reset", OFS_PRIO_B, 32'h0000_0000);
    $display("test reset done");
    ahb(1'b1, OFS_PRIO_A, 32'hFFFF_FF5A);
    rdchk("prio_a rw", OFS_PRIO_A, 32'h0000_005A);
    ahb(1'b1, 12'h008, 32'h0000_00FF);
    rdchk("unmapped", 12'h008, 32'h0000_0000);
    // Spare bits store but leave every line at level 0
    ahb(1'b1, OFS_PRIO_A, 32'h0000_0000);
    ahb(1'b1, OFS_PRIO_B, 32'h0000_0011);
    rdchk("prio_b spare", OFS_PRIO_B, 32'h0000_0011);
    drive({NUM_SRC{1'b1}});
    chk("spare level", 32'h0000_0000, {31'h00000000, irq_level});
    chk("spare source", 32'h0000_0000, {27'h0000000, irq_src});
    $display("test readback done");
    prio_case(SRC_EXT0, 1'b0, BIT_EXT0);
    prio_case(SRC_EXT1, 1'b0, BIT_EXT1);
    prio_case(SRC_EXT2, 1'b0, BIT_EXT2_3);
    prio_case(SRC_EXT3, 1'b0, BIT_EXT2_3);
    prio_case(SRC_EXT4, 1'b0, BIT_EXT4_5);
    prio_case(SRC_EXT5, 1'b0, BIT_EXT4_5);
    prio_case(SRC_WDT_REF, 1'b0, BIT_WDT_REF);
    prio_case(SRC_TIMER0, 1'b0, BIT_TIMER0);
    prio_case(SRC_TIMER1, 1'b0, BIT_TIMER1);
    prio_case(SRC_TIMER2, 1'b0, BIT_TIMER2);
    prio_case(SRC_TIMER3, 1'b1, BIT_TIMER3);
    prio_case(SRC_TIMER4, 1'b1, BIT_TIMER4);
    prio_case(SRC_DMA0, 1'b1, BIT_DMA);
    prio_case(SRC_DMA1, 1'b1, BIT_DMA);
    prio_case(SRC_SERIAL0, 1'b1, BIT_SERIAL0);
    prio_case(SRC_SERIAL1, 1'b1, BIT_SERIAL1);
    prio_case(SRC_ADC, 1'b1, BIT_ADC);
    $display("test field map done");
    // High level first, then lower line number among level 0
    drive('0);
    ahb(1'b1, OFS_PRIO_A, 32'h0000_0000);
    ahb(1'b1, OFS_PRIO_B, 32'h0000_0004);
    @(posedge hclk);
    accept_en <= 1'b1;
    post <= 17'h08009;
    @(posedge hclk);
    post <= '0;
    take_chk(SRC_SERIAL1);
    take_chk(SRC_EXT0);
    take_chk(SRC_EXT3);
    repeat (3) @(posedge hclk);
    #1;
    chk("idle valid", 32'h0000_0000, {31'h00000000, irq_valid});
    accept_en <= 1'b0;
    $display("test order done");
    // Standby clears both registers and hides every request
    ahb(1'b1, OFS_PRIO_A, 32'h0000_00FF);
    ahb(1'b1, OFS_PRIO_B, 32'h0000_00FF);
    @(posedge hclk);
    held <= {NUM_SRC{1'b1}};
    hw_standby <= 1'b1;
    repeat (6) @(posedge hclk);
    #1;
    chk("standby valid", 32'h0000_0000, {31'h00000000, irq_valid});
    @(posedge hclk);
    hw_standby <= 1'b0;
    repeat (4) @(posedge hclk);
    rdchk("prio_a standby", OFS_PRIO_A, 32'h0000_0000);
    rdchk("prio_b standby", OFS_PRIO_B, 32'h0000_0000);
    $display("test standby done");
    tally_and_finish();
  end

  // Whole run is a few hundred cycles; this cuts a hang short
  initial
  begin
    #80000;
    fails++;
    tally_and_finish();
  end
endmodule : ipls_top_tb
